/* File: cos_pkg.sv */
// shared constants and types of the counter output stage and interrupt notifier
package cos_pkg;

  // clock and timing
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned GRID_US       = 50;
  localparam int unsigned GRID_CYC      = (GRID_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned MAX_DELAY_US  = 200;
  localparam int unsigned MAX_DELAY_CYC = (MAX_DELAY_US * 1000000) / CLK_PERIOD_PS;

  // continuous logging
  localparam int unsigned LOG_ENTRIES   = 5120;
  localparam logic [12:0] LOG_LAST      = 13'(LOG_ENTRIES - 1);

  // terminal and factor counts
  localparam int unsigned NUM_EVT       = 4;
  localparam int unsigned NUM_EVT_WIDE  = 2;
  localparam int unsigned NUM_SI        = 8;
  localparam int unsigned NUM_FAC       = 9;
  localparam int unsigned LOG_FAC       = 8;
  localparam int unsigned SI_SRC_W      = 4;

  // register byte offsets
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_EVT_LINK  = 8'h04;
  localparam logic [7:0]  OFS_SI_LINK   = 8'h08;
  localparam logic [7:0]  OFS_STATUS    = 8'h0c;
  localparam logic [7:0]  OFS_LOG_CNT   = 8'h10;
  localparam logic [7:0]  OFS_REQ_CNT   = 8'h14;

  // control fields
  localparam int unsigned CTRL_WIDE_BIT   = 0;
  localparam int unsigned CTRL_SIGNED_BIT = 1;
  localparam int unsigned CTRL_LOGIE_BIT  = 2;

  // event link layout: two bits per terminal
  localparam int unsigned EVT_LINK_CMP  = 0;
  localparam int unsigned EVT_LINK_DET  = 1;

  // interrupt factor source bits, four per factor
  localparam int unsigned SRC_CMP0      = 0;
  localparam int unsigned SRC_CMP1      = 1;
  localparam int unsigned SRC_DET0      = 2;
  localparam int unsigned SRC_DET1      = 3;

  // status fields
  localparam int unsigned STAT_EVT_LSB  = 0;
  localparam int unsigned STAT_PG_BIT   = 4;
  localparam int unsigned STAT_CAM_BIT  = 5;
  localparam int unsigned STAT_PEND_LSB = 8;

  // reset values
  localparam logic [2:0]  CTRL_RST      = 3'h0;
  localparam logic [7:0]  EVT_LINK_RST  = 8'h00;
  localparam logic [31:0] SI_LINK_RST   = 32'h0000_0000;

  typedef logic [15:0] cos_timer_t;

endpackage

/* File: cos_irq_if.sv */
// carrier between the output stage and the interrupt notifier
interface cos_irq_if;
  logic [cos_pkg::NUM_FAC-1:0] factor;
  logic                        req;
  logic [3:0]                  req_id;
  logic [cos_pkg::NUM_FAC-1:0] pending;

  modport stage    (output factor, input req, input req_id, input pending);
  modport notifier (input factor, output req, output req_id, output pending);
endinterface

/* File: cos_notify.sv */
// interrupt notifier: 50 us request grid, per-factor pending and repeat drop
module cos_notify #(
  parameter int unsigned GRID_CYC = cos_pkg::GRID_CYC
) (
  input  wire logic   pclk,
  input  wire logic   presetn,
  cos_irq_if.notifier irq
);

  localparam cos_pkg::cos_timer_t GRID_CYC_M1 = 16'(GRID_CYC - 1);

  typedef struct packed {
    cos_pkg::cos_timer_t          timer;
    logic [cos_pkg::NUM_FAC-1:0]  prev;
    logic [cos_pkg::NUM_FAC-1:0]  seen;
    logic [cos_pkg::NUM_FAC-1:0]  pend;
    logic                         req;
    logic [3:0]                   id;
  } cos_ntf_st_t;

  cos_ntf_st_t                 st_q;
  cos_ntf_st_t                 st_d;
  logic                        tick;
  logic                        found;
  logic [3:0]                  gid;
  logic [cos_pkg::NUM_FAC-1:0] rise;
  logic [cos_pkg::NUM_FAC-1:0] seen_base;
  logic [cos_pkg::NUM_FAC-1:0] accept;
  logic [cos_pkg::NUM_FAC-1:0] cand;
  logic [cos_pkg::NUM_FAC-1:0] grant;

  always_comb begin
    st_d      = st_q;
    tick      = (st_q.timer == GRID_CYC_M1);
    st_d.timer = tick ? '0 : st_q.timer + 16'h0001;
    rise      = irq.factor & ~st_q.prev;
    // a new interval starts at the tick, so a rise in that cycle counts
    seen_base = tick ? '0 : st_q.seen;
    accept    = rise & ~seen_base;
    cand      = st_q.pend | accept;
    grant     = '0;
    gid       = 4'h0;
    found     = 1'b0;
    // highest index first keeps the logging factor within two slots
    for (int i = cos_pkg::NUM_FAC - 1; i >= 0; i--) begin
      if (tick && cand[i] && !found) begin
        grant[i] = 1'b1;
        gid      = 4'(i);
        found    = 1'b1;
      end
    end
    st_d.prev = irq.factor;
    st_d.seen = seen_base | accept;
    st_d.pend = cand & ~grant;
    st_d.req  = found;
    st_d.id   = found ? gid : st_q.id;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign irq.req     = st_q.req;
  assign irq.req_id  = st_q.id;
  assign irq.pending = st_q.pend;

endmodule

/* File: cos_output_stage.sv */
// counter output stage: event, pattern and cam pins, interrupt factors, apb registers
//
// Contract
// - four event terminals in 16-bit mode, only two in 32-bit mode
// - each event terminal drives the event pin of the same index
// - several signals linked to one terminal are combined by OR
// - 16-bit: events 0,1 take comparator 0; events 2,3 comparator 1
// - 16-bit: events 0,1 take detector output 0; events 2,3 output 1
// - 32-bit: detector outputs never feed event terminals
// - pattern pin exists only on 16-bit unsigned counters
// - pattern pin is always driven by the pattern generator
// - cam pin exists only on 32-bit counters, fixed to cam output
// - request interrupt on factor terminal or after 5120 logged entries
// - detector or comparator outputs linked to a factor raise it, except comparator 1 in 32-bit mode
// - logging-complete request only when its enable is set
// - detector output can trigger a request without a comparator
// - requests issue on a 50 us grid, one per slot
// - repeats of one factor within an interval are dropped
// - with logging active the request delay stays under 200 us; code bounds only the logging factor, granted first
module cos_output_stage #(
  parameter int unsigned GRID_CYC = cos_pkg::GRID_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  det_out,
  input  wire logic [1:0]  cmp_out,
  input  wire logic        pg_src,
  input  wire logic        cam_src,
  input  wire logic        log_store,
  output logic      [3:0]  event_pin,
  output logic             pg_pin,
  output logic             cam_pin,
  output logic             irq_req,
  output logic      [3:0]  irq_factor
);

  typedef struct packed {
    logic [2:0]                  ctrl;
    logic [7:0]                  evt_link;
    logic [31:0]                 si_link;
    logic [3:0]                  event_pin;
    logic                        pg_pin;
    logic                        cam_pin;
    logic [cos_pkg::NUM_FAC-1:0] factor;
    logic [12:0]                 log_cnt;
    logic                        log_full;
    logic [15:0]                 req_cnt;
    logic [31:0]                 prdata;
    logic                        pready;
    logic                        pslverr;
  } cos_stage_st_t;

  cos_stage_st_t st_q;
  cos_stage_st_t st_d;

  cos_irq_if irq_bus ();

  logic                        wide;
  logic                        signed_cnt;
  logic                        pg_present;
  logic                        setup;
  logic                        access;
  logic                        mapped;
  logic                        writable;
  logic [31:0]                 wmask;
  logic [31:0]                 rd_word;
  logic [3:0]                  evt_v;
  logic [3:0]                  src_vec;
  logic                        cmp_sel;
  logic                        det_sel;
  logic [cos_pkg::NUM_FAC-1:0] fac_v;

  // byte lane mask of the write strobes
  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = '0;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{strb[b]}};
    end
    return m;
  endfunction

  // decode of the address in the setup cycle
  function automatic logic is_mapped(input logic [7:0] a);
    logic hit;
    hit = 1'b0;
    case (a)
      cos_pkg::OFS_CTRL,
      cos_pkg::OFS_EVT_LINK,
      cos_pkg::OFS_SI_LINK,
      cos_pkg::OFS_STATUS,
      cos_pkg::OFS_LOG_CNT,
      cos_pkg::OFS_REQ_CNT: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction

  always_comb begin
    st_d       = st_q;
    wide       = st_q.ctrl[cos_pkg::CTRL_WIDE_BIT];
    signed_cnt = st_q.ctrl[cos_pkg::CTRL_SIGNED_BIT];
    pg_present = ~wide & ~signed_cnt;

    // event output terminals
    evt_v   = '0;
    cmp_sel = 1'b0;
    det_sel = 1'b0;
    for (int k = 0; k < cos_pkg::NUM_EVT; k++) begin
      // 16-bit pairs terminals on comparator/detector k/2
      cmp_sel = wide ? cmp_out[0] : cmp_out[k/2];
      det_sel = det_out[k/2] & ~wide;
      evt_v[k] = (st_q.evt_link[2*k + cos_pkg::EVT_LINK_CMP] & cmp_sel)
               | (st_q.evt_link[2*k + cos_pkg::EVT_LINK_DET] & det_sel);
      if (wide && (k >= cos_pkg::NUM_EVT_WIDE)) begin
        evt_v[k] = 1'b0;
      end
    end
    st_d.event_pin = evt_v;

    // pattern and cam pins, hard-linked, low where the pin is absent
    st_d.pg_pin  = pg_present & pg_src;
    st_d.cam_pin = wide & cam_src;

    // continuous logging entry counter
    st_d.log_full = 1'b0;
    if (log_store) begin
      if (st_q.log_cnt == cos_pkg::LOG_LAST) begin
        st_d.log_cnt  = '0;
        st_d.log_full = 1'b1;
      end else begin
        st_d.log_cnt = st_q.log_cnt + 13'h0001;
      end
    end

    // interrupt factor terminals
    src_vec = '0;
    src_vec[cos_pkg::SRC_CMP0] = cmp_out[0];
    src_vec[cos_pkg::SRC_CMP1] = cmp_out[1] & ~wide;
    src_vec[cos_pkg::SRC_DET0] = det_out[0];
    src_vec[cos_pkg::SRC_DET1] = det_out[1];
    fac_v = '0;
    for (int s = 0; s < cos_pkg::NUM_SI; s++) begin
      fac_v[s] = |(st_q.si_link[s*cos_pkg::SI_SRC_W +: cos_pkg::SI_SRC_W] & src_vec);
    end
    fac_v[cos_pkg::LOG_FAC] = st_q.log_full
                            & st_q.ctrl[cos_pkg::CTRL_LOGIE_BIT];
    st_d.factor = fac_v;

    // issued request counter
    if (irq_bus.req) begin
      st_d.req_cnt = st_q.req_cnt + 16'h0001;
    end

    // apb slave: answer in the first access cycle
    setup    = psel & ~penable;
    access   = psel & penable & st_q.pready;
    mapped   = is_mapped(paddr);
    writable = (paddr == cos_pkg::OFS_CTRL)
             | (paddr == cos_pkg::OFS_EVT_LINK)
             | (paddr == cos_pkg::OFS_SI_LINK);
    wmask    = strb_mask(pstrb);

    rd_word = '0;
    case (paddr)
      cos_pkg::OFS_CTRL: begin
        rd_word[2:0] = st_q.ctrl;
      end
      cos_pkg::OFS_EVT_LINK: begin
        rd_word[7:0] = st_q.evt_link;
      end
      cos_pkg::OFS_SI_LINK: begin
        rd_word = st_q.si_link;
      end
      cos_pkg::OFS_STATUS: begin
        rd_word[cos_pkg::STAT_EVT_LSB +: cos_pkg::NUM_EVT] = st_q.event_pin;
        rd_word[cos_pkg::STAT_PG_BIT]  = st_q.pg_pin;
        rd_word[cos_pkg::STAT_CAM_BIT] = st_q.cam_pin;
        rd_word[cos_pkg::STAT_PEND_LSB +: cos_pkg::NUM_FAC] = irq_bus.pending;
      end
      cos_pkg::OFS_LOG_CNT: begin
        rd_word[12:0] = st_q.log_cnt;
      end
      cos_pkg::OFS_REQ_CNT: begin
        rd_word[15:0] = st_q.req_cnt;
      end
      default: begin
        rd_word = '0;
      end
    endcase

    st_d.pready  = setup;
    st_d.pslverr = setup & ~mapped;
    if (setup) begin
      st_d.prdata = (mapped && !pwrite) ? rd_word : 32'h0000_0000;
    end

    if (access && pwrite && !st_q.pslverr && writable) begin
      case (paddr)
        cos_pkg::OFS_CTRL: begin
          st_d.ctrl = (st_q.ctrl & ~wmask[2:0]) | (pwdata[2:0] & wmask[2:0]);
        end
        cos_pkg::OFS_EVT_LINK: begin
          st_d.evt_link = (st_q.evt_link & ~wmask[7:0]) | (pwdata[7:0] & wmask[7:0]);
        end
        cos_pkg::OFS_SI_LINK: begin
          st_d.si_link = (st_q.si_link & ~wmask) | (pwdata & wmask);
        end
        default: begin
          st_d.ctrl = st_q.ctrl;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q          <= '0;
      st_q.ctrl     <= cos_pkg::CTRL_RST;
      st_q.evt_link <= cos_pkg::EVT_LINK_RST;
      st_q.si_link  <= cos_pkg::SI_LINK_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign irq_bus.factor = st_q.factor;

  cos_notify #(
    .GRID_CYC (GRID_CYC)
  ) u_notify (
    .pclk    (pclk),
    .presetn (presetn),
    .irq     (irq_bus)
  );

  assign prdata     = st_q.prdata;
  assign pready     = st_q.pready;
  assign pslverr    = st_q.pslverr;
  assign event_pin  = st_q.event_pin;
  assign pg_pin     = st_q.pg_pin;
  assign cam_pin    = st_q.cam_pin;
  assign irq_req    = irq_bus.req;
  assign irq_factor = irq_bus.req_id;

endmodule

/* File: cos_chk.sv */
// assertion checker on the ports of the counter output stage
module cos_chk #(
  parameter int unsigned GRID_CYC = cos_pkg::GRID_CYC
) (
  input logic        pclk,
  input logic        presetn,
  input logic [7:0]  paddr,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [31:0] pwdata,
  input logic [3:0]  pstrb,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic [1:0]  det_out,
  input logic [1:0]  cmp_out,
  input logic        pg_src,
  input logic        cam_src,
  input logic        log_store,
  input logic [3:0]  event_pin,
  input logic        pg_pin,
  input logic        cam_pin,
  input logic        irq_req,
  input logic [3:0]  irq_factor
);
  logic [2:0]  ctl_q;
  logic [7:0]  lnk_q;
  logic [15:0] tmr_q;
  logic [3:0]  ev;
  logic [3:0]  ev32;
  logic        wr;
  assign wr = psel & penable & pready & pwrite & pstrb[0];
  assign ev32 = {2'h0, lnk_q[2] & cmp_out[0], lnk_q[0] & cmp_out[0]};
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      ev[k] = (lnk_q[2*k] & cmp_out[k/2]) | (lnk_q[2*k+1] & det_out[k/2]);
    end
  end
  // shadow of mode and link registers, and of the grid timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= '0;
      lnk_q <= '0;
      tmr_q <= '0;
    end else begin
      tmr_q <= (tmr_q == 16'(GRID_CYC - 1)) ? '0 : tmr_q + 16'h1;
      if (wr && paddr == cos_pkg::OFS_CTRL) begin
        ctl_q <= pwdata[2:0];
      end
      if (wr && paddr == cos_pkg::OFS_EVT_LINK) begin
        lnk_q <= pwdata[7:0];
      end
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_evt16;
    !ctl_q[0] |=> event_pin == $past(ev);
  endproperty
  a_evt16: assert property (p_evt16) else $error("16-bit event pins wrong");
  property p_evt32;
    ctl_q[0] |=> event_pin == $past(ev32);
  endproperty
  a_evt32: assert property (p_evt32) else $error("32-bit event pins wrong");
  property p_pg;
    1'h1 |=> pg_pin == ($past(pg_src) & ~|$past(ctl_q[1:0]));
  endproperty
  a_pg: assert property (p_pg) else $error("pattern pin wrong");
  property p_cam;
    1'h1 |=> cam_pin == ($past(cam_src) & $past(ctl_q[0]));
  endproperty
  a_cam: assert property (p_cam) else $error("cam pin wrong");
  property p_grid;
    irq_req |-> tmr_q == 16'h0;
  endproperty
  a_grid: assert property (p_grid) else $error("request off the grid");
  property p_logie;
    irq_req && irq_factor == 4'h8 |-> ctl_q[2];
  endproperty
  a_logie: assert property (p_logie) else $error("logging request while disabled");
  property p_facrng;
    irq_req |-> irq_factor <= 4'h8;
  endproperty
  a_facrng: assert property (p_facrng) else $error("factor id out of range");
  property p_hold;
    !irq_req |-> $stable(irq_factor);
  endproperty
  a_hold: assert property (p_hold) else $error("factor id moved");
endmodule

bind cos_output_stage cos_chk #(.GRID_CYC(GRID_CYC)) u_chk (
  .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready,
  .pslverr, .det_out, .cmp_out, .pg_src, .cam_src, .log_store, .event_pin, .pg_pin,
  .cam_pin, .irq_req, .irq_factor
);

/* File: cos_host.sv */
// host model: takes requests and runs the handler of each factor
module cos_host #(
  parameter int unsigned PTR_START = 50,
  parameter int unsigned PTR_COUNT = 9,
  parameter bit          PTR_SET   = 1'h1
) (
  input  logic       pclk,
  input  logic       presetn,
  input  logic       irq_req,
  input  logic [3:0] irq_factor,
  input  logic       clr,
  output logic [7:0] total,
  output logic [7:0] ptr,
  output logic       err
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      total <= '0;
      ptr   <= '0;
      err   <= 1'h0;
    end else if (clr) begin
      total <= '0;
    end else if (irq_req) begin
      total <= total + 8'h1;
      ptr   <= 8'(PTR_START) + 8'(irq_factor);
      err   <= err | !PTR_SET | (irq_factor >= 4'(PTR_COUNT));
    end
  end
endmodule

/* File: counter_output_stage_and_interrupt_test.sv */
// self-checking bench of the counter output stage and interrupt notifier
module counter_output_stage_and_interrupt_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned G = 20;
  typedef struct packed {
    logic [2:0] ctl;
    logic [7:0] lnk;
    logic [1:0] cmp;
    logic [1:0] det;
    logic [1:0] src;
    logic [5:0] exp;
  } cos_row_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, pg_src, cam_src;
  logic        log_store, pg_pin, cam_pin, irq_req, clr, err, er;
  logic [1:0]  det_out, cmp_out;
  logic [3:0]  pstrb, event_pin, irq_factor;
  logic [7:0]  paddr, total, ptr;
  logic [31:0] pwdata, prdata, rd;
  int          fail_count = 0;
  int          checked = 0;
  // src is pattern, cam; exp is event pins, pattern pin, cam pin
  cos_row_t rows [8] = '{
    '{3'h0, 8'h55, 2'h1, 2'h0, 2'h3, 6'h0e},
    '{3'h0, 8'h55, 2'h2, 2'h0, 2'h1, 6'h30},
    '{3'h0, 8'haa, 2'h0, 2'h1, 2'h0, 6'h0c},
    '{3'h0, 8'haa, 2'h0, 2'h2, 2'h0, 6'h30},
    '{3'h0, 8'hff, 2'h1, 2'h2, 2'h0, 6'h3c},
    '{3'h2, 8'h55, 2'h3, 2'h0, 2'h3, 6'h3c},
    '{3'h1, 8'hff, 2'h3, 2'h3, 2'h3, 6'h0d},
    '{3'h1, 8'haa, 2'h0, 2'h3, 2'h1, 6'h01}
  };
  cos_output_stage #(.GRID_CYC(G)) dut (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .det_out, .cmp_out, .pg_src, .cam_src, .log_store, .event_pin, .pg_pin,
    .cam_pin, .irq_req, .irq_factor
  );
  cos_host host (.pclk, .presetn, .irq_req, .irq_factor, .clr, .total, .ptr, .err);
  always #2.5 pclk = ~pclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic logn(input int n);
    repeat (n) begin
      log_store <= 1'h1;
      @(posedge pclk);
      log_store <= 1'h0;
      @(posedge pclk);
    end
  endtask
  task automatic wirq(input int n);
    for (int i = 0; i < n && irq_req !== 1'h1; i++) begin
      @(posedge pclk);
    end
  endtask
  task automatic results();
    if (fail_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #300000;
    fail_count++;
    results();
  end
  initial begin
    {pclk, presetn, psel, penable, pwrite, log_store, clr, pg_src, cam_src} = '0;
    {paddr, pwdata, det_out, cmp_out} = '0;
    pstrb = 4'hf;
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    chk({event_pin, pg_pin, cam_pin, irq_req, irq_factor}, '0);
    for (int i = 0; i < 3; i++) begin
      apb(1'h0, 8'(4 * i), '0);
      chk(rd, '0);
    end
    apb(1'h0, 8'h41, '0);
    chk({er, rd[30:0]}, 32'h8000_0000);
    foreach (rows[i]) begin
      apb(1'h1, cos_pkg::OFS_CTRL, 32'(rows[i].ctl));
      apb(1'h1, cos_pkg::OFS_EVT_LINK, 32'(rows[i].lnk));
      cmp_out <= rows[i].cmp;
      det_out <= rows[i].det;
      {pg_src, cam_src} <= rows[i].src;
      repeat (2) @(posedge pclk);
      chk({event_pin, pg_pin, cam_pin}, rows[i].exp);
    end
    // reset in mid-run: pins drop at once, mode and links back to zero
    presetn <= 1'h0;
    @(posedge pclk);
    chk({event_pin, pg_pin, cam_pin, irq_req, irq_factor}, '0);
    @(posedge pclk);
    presetn <= 1'h1;
    repeat (2) @(posedge pclk);
    chk({event_pin, pg_pin, cam_pin}, '0);
    apb(1'h0, cos_pkg::OFS_EVT_LINK, '0);
    chk(rd, '0);
    {cmp_out, det_out} <= '0;
    apb(1'h1, cos_pkg::OFS_CTRL, 32'h0);
    apb(1'h1, cos_pkg::OFS_SI_LINK, 32'h0000_0014);
    cmp_out <= 2'h1;
    @(posedge pclk);
    cmp_out <= 2'h0;
    wirq(3 * G);
    chk(irq_req, 1'h1);
    chk(irq_factor, 4'h1);
    // just after a tick: two factors and a repeat in one interval
    clr <= 1'h1;
    {cmp_out, det_out} <= 4'h5;
    @(posedge pclk);
    clr <= 1'h0;
    {cmp_out, det_out} <= 4'h0;
    @(posedge pclk);
    det_out <= 2'h1;
    @(posedge pclk);
    det_out <= 2'h0;
    apb(1'h0, cos_pkg::OFS_STATUS, '0);
    chk(rd, 32'h0000_0300);
    repeat (3 * G) @(posedge pclk);
    chk(total, 8'h2);
    chk({err, ptr}, 9'h032);
    logn(5120);
    repeat (3 * G) @(posedge pclk);
    chk(total, 8'h2);
    apb(1'h1, cos_pkg::OFS_CTRL, 32'h4);
    logn(5119);
    apb(1'h0, cos_pkg::OFS_LOG_CNT, '0);
    chk(rd, 32'(cos_pkg::LOG_LAST));
    logn(1);
    wirq(2 * G + 4);
    chk(irq_req, 1'h1);
    chk(irq_factor, 4'h8);
    @(posedge pclk);
    chk(ptr, 8'h3a);
    apb(1'h0, cos_pkg::OFS_REQ_CNT, '0);
    chk(rd, 32'h0000_0004);
    results();
  end
endmodule
